// ==== hw/ldm_pkg.sv ====
package ldm_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned CLK_NS       = 20;
    // measurement counter width: 16 bits resolves far better than 200:1
    localparam int unsigned DUTY_W       = 16;
    localparam int unsigned DUTY_FULL    = 65535;
    // mix output frequencies in Hz
    localparam int unsigned MIX_LO_HZ    = 200;
    localparam int unsigned MIX_HI_HZ    = 23000;
    localparam int unsigned MIX_LO_CYC   = CLK_HZ / MIX_LO_HZ;
    localparam int unsigned MIX_HI_CYC   = CLK_HZ / MIX_HI_HZ;
    // deep dimming on-time limit, ns
    localparam int unsigned DEEP_NS      = 7000;
    localparam int unsigned DEEP_CYC     = (DEEP_NS + CLK_NS - 1) / CLK_NS;
    // short check delay, us
    localparam int unsigned SHORT_US     = 500;
    localparam int unsigned SHORT_CYC    = SHORT_US * 1000 / CLK_NS;
    // minimum boost on-time, ns
    localparam int unsigned MINON_NS     = 100;
    localparam int unsigned MINON_CYC    = (MINON_NS + CLK_NS - 1) / CLK_NS;
    // strap decode codes
    localparam logic [1:0]  STRAP_LOW    = 2'h0;
    localparam logic [1:0]  STRAP_MID    = 2'h1;
    localparam logic [1:0]  STRAP_HIGH   = 2'h2;
    localparam logic [1:0]  STRAP_FLOAT  = 2'h3;
    localparam logic [1:0]  MODE_MIX     = 2'h0;
    localparam logic [1:0]  MODE_PWM     = 2'h1;
    localparam logic [1:0]  MODE_ANALOG  = 2'h2;
    localparam int unsigned NSTR         = 6;

    typedef enum logic [1:0] {
        DIM_MIX    = 2'b00,
        DIM_PWM    = 2'b01,
        DIM_ANALOG = 2'b10
    } ldm_dim_e;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_WAIT   = 3'b001,
        ST_CHECK  = 3'b010,
        ST_BOOST  = 3'b011,
        ST_LATCH  = 3'b100
    } ldm_st_e;
endpackage : ldm_pkg

// ==== hw/ldm_core.sv ====
`timescale 1ns/10ps
//
// Contract
// - strap low, or float with mode field 00, selects mix dimming.
// - strap middle, or float with mode field 01, selects direct PWM.
// - strap high, or float with mode field 10, selects analog dimming.
// - mix above transfer point: amplitude follows measured input duty.
// - mix below 25% point: amplitude quarter scale, output duty four times input.
// - mix transfer point is 12.5% or 25%, chosen by a bit.
// - mix output PWM at 200Hz, or 23kHz when selected, independent of input.
// - direct PWM: full amplitude, strings follow input exactly.
// - analog: counter measures input duty; amplitude is full scale times duty.
// - analog with duty below 10% raises sink regulation target to 2V.
// - analog amplitude resolves at least a 200:1 duty range.
// - output on-time under 7us moves boost target to 93% of overvoltage.
// - string count field 000..101 enables six down to one string.
// - strings grounded at start-up are excluded, highest channel downward.
// - on enable drive disconnect gate; after 500us, low output sense latches off.
// - after short check, other safety checks must pass before soft start.
// - boost switch turns on each cycle for at least about 100ns.
// - light load skips pulses after a minimum on-time.
// - lowest active non-excluded sink voltage is the regulation feedback.
// - all logic held disabled until internal supply leaves lockout.
// - transfer point select bit zero picks 25%.
module ldm_core
    import ldm_pkg::*;
#(
    parameter int unsigned SHORT_CYCLES = SHORT_CYC
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // supply and enable
    input  wire logic                supplyOk,
    input  wire logic                enable,
    // configuration
    input  wire logic [1:0]          strapLevel,
    input  wire logic [1:0]          dim_method_select,
    input  wire logic                blend_transfer_point_select,
    input  wire logic                blend_output_freq_select,
    input  wire logic [2:0]          string_count_select,
    // dimming input, analog sense comparators, safety status and boost switch clock
    input  wire logic                pwm_brightness_input,
    input  wire logic                output_overvoltage_sense,
    input  wire logic [NSTR-1:0]     sinkGrounded,
    input  wire logic [NSTR-1:0]     sinkLowest,
    input  wire logic                safetyOk,
    input  wire logic                boostNeeded,
    input  wire logic                switchClock,
    // outputs
    output logic                     input_disconnect_gate,
    output logic                     softStart,
    output logic                     latchedOff,
    output logic [1:0]               activeMode,
    output logic [DUTY_W-1:0]        amplitude,
    output logic [NSTR-1:0]          string_sink_pin,
    output logic [NSTR-1:0]          feedbackSelect,
    output logic                     sinkTargetHigh,
    output logic                     deepDimming,
    output logic                     boostSwitch
);
    typedef struct packed {
        ldm_st_e             st;
        logic [31:0]         tmr;
        logic [NSTR-1:0]     excl;
        logic                dinPrev;
        logic [DUTY_W-1:0]   hiCnt;
        logic [DUTY_W-1:0]   perCnt;
        logic [DUTY_W-1:0]   duty;
        logic [31:0]         mixCnt;
        logic [31:0]         onCnt;
        logic [31:0]         lastOn;
        logic                outOn;
        logic [DUTY_W-1:0]   amp;
        logic [NSTR-1:0]     strOut;
        logic [NSTR-1:0]     fb;
        logic                tgtHi;
        logic                deep;
        logic [7:0]          swCnt;
        logic                sw;
        logic                swPrev;
        logic                gate;
        logic [1:0]          mode;
    } ldm_s;

    ldm_s cur;
    ldm_s next_cur;

    logic [1:0]          modeSel;
    logic [NSTR-1:0]     countMask;
    logic [NSTR-1:0]     useMask;
    logic [31:0]         mixPeriod;
    logic [31:0]         mixOnLen;
    logic [DUTY_W+3:0]   scaled;
    logic [DUTY_W-1:0]   tpoint;
    logic [NSTR-1:0]     lowestMask;

    // mode decode with strap precedence
    always_comb begin
        unique case (strapLevel)
            STRAP_LOW:  modeSel = MODE_MIX;
            STRAP_MID:  modeSel = MODE_PWM;
            STRAP_HIGH: modeSel = MODE_ANALOG;
            default:    modeSel = (dim_method_select == 2'h3) ? MODE_MIX : dim_method_select;
        endcase
    end

    always_comb begin
        unique case (string_count_select)
            3'h0:    countMask = 6'h3F;
            3'h1:    countMask = 6'h1F;
            3'h2:    countMask = 6'h0F;
            3'h3:    countMask = 6'h07;
            3'h4:    countMask = 6'h03;
            3'h5:    countMask = 6'h01;
            default: countMask = 6'h3F;
        endcase
    end

    assign useMask = countMask & ~cur.excl;
    assign lowestMask = sinkLowest & useMask;

    assign tpoint = blend_transfer_point_select ? DUTY_W'(DUTY_FULL / 8) : DUTY_W'(DUTY_FULL / 4);
    assign mixPeriod = blend_output_freq_select ? MIX_HI_CYC : MIX_LO_CYC;
    assign scaled = blend_transfer_point_select ? ({4'h0, cur.duty} << 3) : ({4'h0, cur.duty} << 2);
    assign mixOnLen = 32'((64'(scaled) * 64'(mixPeriod)) / 64'(DUTY_FULL));

    always_comb begin
        next_cur = cur;
        next_cur.mode = modeSel;
        next_cur.dinPrev = pwm_brightness_input;
        next_cur.swPrev = switchClock;
        unique case (cur.st)
            ST_OFF: begin
                next_cur.gate = 1'b0;
                if (enable) begin
                    next_cur.gate = 1'b1;
                    next_cur.tmr = 32'h0;
                    next_cur.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_cur.tmr = cur.tmr + 32'h1;
                if (cur.tmr >= SHORT_CYCLES - 1) begin
                    if (!output_overvoltage_sense) begin
                        next_cur.st = ST_LATCH;
                        next_cur.gate = 1'b0;
                    end else begin
                        next_cur.excl = sinkGrounded;
                        next_cur.st = ST_CHECK;
                    end
                end
            end
            ST_CHECK: if (safetyOk) begin
                next_cur.st = ST_BOOST;
            end
            ST_BOOST: if (!enable) begin
                next_cur.st = ST_OFF;
            end
            ST_LATCH: next_cur.gate = 1'b0;
            default: next_cur.st = ST_OFF;
        endcase

        if (pwm_brightness_input && !cur.dinPrev) begin
            next_cur.perCnt = DUTY_W'(1);
            next_cur.hiCnt = DUTY_W'(1);
            if (cur.perCnt != '0) begin
                next_cur.duty = DUTY_W'((64'(cur.hiCnt) * 64'(DUTY_FULL)) / 64'(cur.perCnt));
            end
        end else begin
            if (cur.perCnt != DUTY_W'(DUTY_FULL)) begin
                next_cur.perCnt = cur.perCnt + DUTY_W'(1);
            end
            if (pwm_brightness_input && cur.hiCnt != DUTY_W'(DUTY_FULL)) begin
                next_cur.hiCnt = cur.hiCnt + DUTY_W'(1);
            end
        end

        next_cur.mixCnt = (cur.mixCnt + 32'h1 >= mixPeriod) ? 32'h0 : cur.mixCnt + 32'h1;

        next_cur.amp = DUTY_W'(DUTY_FULL);
        next_cur.outOn = pwm_brightness_input;
        next_cur.tgtHi = 1'b0;
        unique case (cur.mode)
            MODE_MIX: begin
                if (cur.duty > tpoint) begin
                    next_cur.amp = cur.duty;
                    next_cur.outOn = 1'b1;
                end else begin
                    next_cur.amp = tpoint;
                    next_cur.outOn = cur.mixCnt < mixOnLen;
                end
            end
            MODE_PWM: next_cur.outOn = pwm_brightness_input;
            MODE_ANALOG: begin
                next_cur.amp = cur.duty;
                next_cur.outOn = 1'b1;
                next_cur.tgtHi = cur.duty < DUTY_W'(DUTY_FULL / 10);
            end
            default: next_cur.outOn = 1'b0;
        endcase
        if (next_cur.st != ST_BOOST) begin
            next_cur.outOn = 1'b0;
        end
        next_cur.strOut = next_cur.outOn ? useMask : '0;
        next_cur.fb = lowestMask;

        if (cur.outOn) begin
            next_cur.onCnt = cur.onCnt + 32'h1;
        end else if (cur.onCnt != 32'h0) begin
            next_cur.lastOn = cur.onCnt;
            next_cur.onCnt = 32'h0;
        end
        next_cur.deep = (cur.lastOn != 32'h0) && (cur.lastOn < DEEP_CYC);

        // switch on per cycle, min on-time, skip
        if (next_cur.st != ST_BOOST) begin
            next_cur.sw = 1'b0;
            next_cur.swCnt = 8'h0;
        end else if (switchClock && !cur.swPrev && boostNeeded) begin
            next_cur.sw = 1'b1;
            next_cur.swCnt = 8'h0;
        end else if (cur.sw) begin
            next_cur.swCnt = cur.swCnt + 8'h1;
            if (cur.swCnt >= 8'(MINON_CYC - 1)) begin
                next_cur.sw = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !supplyOk) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign input_disconnect_gate = cur.gate;
    assign softStart             = (cur.st == ST_BOOST);
    assign latchedOff            = (cur.st == ST_LATCH);
    assign activeMode            = cur.mode;
    assign amplitude             = cur.amp;
    assign string_sink_pin       = cur.strOut;
    assign feedbackSelect        = cur.fb;
    assign sinkTargetHigh        = cur.tgtHi;
    assign deepDimming           = cur.deep;
    assign boostSwitch           = cur.sw;

    property p_short;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (cur.st == ST_WAIT && cur.tmr >= SHORT_CYCLES - 1 && !output_overvoltage_sense)
        |=> latchedOff && !input_disconnect_gate;
    endproperty
    a_short: assert property (p_short) else $error("short not latched");

    property p_strap;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (strapLevel == STRAP_MID) |=> (activeMode == MODE_PWM);
    endproperty
    a_strap: assert property (p_strap) else $error("strap mid not pwm");

    property p_pwm;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (cur.mode == MODE_PWM && cur.st == ST_BOOST) |=> amplitude == DUTY_W'(DUTY_FULL);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm amplitude not full");

    property p_count;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (string_count_select == 3'h5) |=> (string_sink_pin[NSTR-1:1] == '0);
    endproperty
    a_count: assert property (p_count) else $error("extra string enabled");

    property p_minon;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        $rose(boostSwitch) && cur.st == ST_BOOST |-> boostSwitch [*5];
    endproperty
    a_minon: assert property (p_minon) else $error("on-time too short");

    property p_off;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        !softStart |-> string_sink_pin == '0 && !boostSwitch;
    endproperty
    a_off: assert property (p_off) else $error("active before start");

    property p_tgt;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (cur.mode == MODE_ANALOG && cur.duty >= DUTY_W'(DUTY_FULL / 10)) |=> !sinkTargetHigh;
    endproperty
    a_tgt: assert property (p_tgt) else $error("target raised wrongly");

    property p_blend;
        @(posedge clk_sys) disable iff (srst || !supplyOk)
        (cur.mode == MODE_MIX && cur.duty > tpoint) |=> amplitude == $past(cur.duty);
    endproperty
    a_blend: assert property (p_blend) else $error("mix amplitude wrong");
endmodule : ldm_core

// ==== tb/ldm_ctrl_model.sv ====
`timescale 1ns/10ps
module ldm_ctrl_model (
    // clock
    input  wire logic        clk_sys,
    // dimming setup
    input  wire logic        run,
    input  wire logic [15:0] periodCyc,
    input  wire logic [15:0] highCyc,
    // dimming line
    output logic             pwmOut
);
    logic [15:0] cnt;

    initial begin
        cnt    = 16'h0;
        pwmOut = 1'b0;
    end

    always @(negedge clk_sys) begin
        cnt    <= (cnt >= periodCyc - 16'h1) ? 16'h0 : cnt + 16'h1;
        pwmOut <= run && (cnt < highCyc);
    end
endmodule : ldm_ctrl_model

// ==== tb/test_led_dimming_mode_control.sv ====
`timescale 1ns/10ps
module test_led_dimming_mode_control
    import ldm_pkg::*;
;
    typedef struct packed {
        logic [1:0] strap;
        logic [1:0] field;
        logic [2:0] count;
        logic [1:0] mode;
        logic [5:0] mask;
    } ldm_row_s;

    logic              clk_sys, srst, supplyOk, enable, run, pwmIn, probe;
    logic              blend_transfer_point_select, blend_output_freq_select;
    logic              output_overvoltage_sense, safetyOk, boostNeeded, switchClock;
    logic              input_disconnect_gate, softStart, latchedOff;
    logic              sinkTargetHigh, deepDimming, boostSwitch;
    logic [1:0]        strapLevel, dim_method_select, activeMode, sel;
    logic [2:0]        string_count_select;
    logic [5:0]        sinkGrounded, sinkLowest, string_sink_pin, feedbackSelect;
    logic [DUTY_W-1:0] amplitude;
    logic [15:0]       highCyc;
    int                n_mismatch, check_count, w, p, k;
    int                hiA [3] = '{1250, 200, 13};
    ldm_row_s          rows [14] = '{
        '{2'h0, 2'h1, 3'h0, 2'h0, 6'h3F}, '{2'h1, 2'h2, 3'h0, 2'h1, 6'h3F},
        '{2'h2, 2'h0, 3'h0, 2'h2, 6'h3F}, '{2'h3, 2'h0, 3'h0, 2'h0, 6'h3F},
        '{2'h3, 2'h1, 3'h0, 2'h1, 6'h3F}, '{2'h3, 2'h2, 3'h0, 2'h2, 6'h3F},
        '{2'h3, 2'h3, 3'h0, 2'h0, 6'h3F}, '{2'h1, 2'h0, 3'h1, 2'h1, 6'h1F},
        '{2'h1, 2'h0, 3'h2, 2'h1, 6'h0F}, '{2'h1, 2'h0, 3'h3, 2'h1, 6'h07},
        '{2'h1, 2'h0, 3'h4, 2'h1, 6'h03}, '{2'h1, 2'h0, 3'h5, 2'h1, 6'h01},
        '{2'h1, 2'h0, 3'h6, 2'h1, 6'h3F}, '{2'h1, 2'h0, 3'h7, 2'h1, 6'h3F}};

    assign probe = (sel == 2'h0) ? softStart :
                   (sel == 2'h1) ? input_disconnect_gate : string_sink_pin[0];

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    ldm_ctrl_model ctrl (.clk_sys(clk_sys), .run(run), .periodCyc(16'h09C4),
        .highCyc(highCyc), .pwmOut(pwmIn));

    ldm_core #(.SHORT_CYCLES(20)) dut (.clk_sys(clk_sys), .srst(srst),
        .supplyOk(supplyOk), .enable(enable), .strapLevel(strapLevel),
        .dim_method_select(dim_method_select),
        .blend_transfer_point_select(blend_transfer_point_select),
        .blend_output_freq_select(blend_output_freq_select),
        .string_count_select(string_count_select), .pwm_brightness_input(pwmIn),
        .output_overvoltage_sense(output_overvoltage_sense), .sinkGrounded(sinkGrounded),
        .sinkLowest(sinkLowest), .safetyOk(safetyOk), .boostNeeded(boostNeeded),
        .switchClock(switchClock), .input_disconnect_gate(input_disconnect_gate),
        .softStart(softStart), .latchedOff(latchedOff), .activeMode(activeMode),
        .amplitude(amplitude), .string_sink_pin(string_sink_pin),
        .feedbackSelect(feedbackSelect), .sinkTargetHigh(sinkTargetHigh),
        .deepDimming(deepDimming), .boostSwitch(boostSwitch));

    function int d16(input int h);
        return h * 65535 / 2500;
    endfunction : d16

    function logic near(input int a, input int b, input int t);
        return ((a > b) ? a - b : b - a) <= t;
    endfunction : near

    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task waitProbe(input logic [1:0] s, input logic v, input int lim);
        int i;
        sel = s;
        // let the probe mux follow the new select before looking
        #1;
        i = 0;
        while (probe !== v && i < lim) begin
            cyc(1);
            i++;
        end
        check(probe, v);
        if (probe !== v) end_of_test();
    endtask : waitProbe

    task pulse(output int wd, output int pd);
        waitProbe(2'h2, 1'b0, 5000);
        waitProbe(2'h2, 1'b1, 5000);
        wd = 0;
        while (probe === 1'b1 && wd < 9000) begin
            cyc(1);
            wd++;
        end
        pd = wd;
        while (probe === 1'b0 && pd < 9000) begin
            cyc(1);
            pd++;
        end
    endtask : pulse

    task settle(input logic [15:0] h);
        highCyc = h;
        cyc(7500);
    endtask : settle

    task startUp;
        output_overvoltage_sense = 1'b1;
        safetyOk = 1'b0;
        enable = 1'b1;
        waitProbe(2'h1, 1'b1, 4);
        cyc(10);
        check(softStart, 1'b0);
        cyc(30);
        check(softStart, 1'b0);
        safetyOk = 1'b1;
        waitProbe(2'h0, 1'b1, 4);
    endtask : startUp

    initial begin
        {srst, supplyOk, enable, run, sel} = 6'h30;
        {strapLevel, dim_method_select, string_count_select} = 7'h60;
        {blend_transfer_point_select, blend_output_freq_select} = 2'h1;
        {output_overvoltage_sense, safetyOk, boostNeeded, switchClock} = 4'h0;
        sinkGrounded = 6'h00;
        sinkLowest = 6'h01;
        highCyc = 16'hFFFF;
        n_mismatch = 0;
        check_count = 0;
        cyc(20);
        check({input_disconnect_gate, softStart, latchedOff, amplitude}, 0);
        srst = 1'b0;
        enable = 1'b1;
        waitProbe(2'h1, 1'b1, 4);
        cyc(30);
        check(latchedOff, 1'b1);
        enable = 1'b0;
        cyc(2);
        enable = 1'b1;
        cyc(30);
        check({latchedOff, softStart}, 2'h2);
        enable = 1'b0;
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        cyc(1);
        startUp();
        run = 1'b1;
        for (k = 0; k < 14; k++) begin
            {strapLevel, dim_method_select, string_count_select} = rows[k][14:8];
            cyc(3);
            check(activeMode, rows[k].mode);
            if (rows[k].mode == 2'h1) check(string_sink_pin, rows[k].mask);
        end
        strapLevel = 2'h1;
        string_count_select = 3'h0;
        settle(200);
        check(deepDimming, 1'b1);
        check(amplitude, 16'hFFFF);
        settle(1250);
        check(deepDimming, 1'b0);
        strapLevel = 2'h2;
        for (k = 0; k < 3; k++) begin
            settle(hiA[k]);
            check(amplitude, d16(hiA[k]));
            check(sinkTargetHigh, hiA[k] < 250);
        end
        strapLevel = 2'h0;
        blend_transfer_point_select = 1'b0;
        settle(1250);
        check(amplitude, d16(1250));
        for (k = 0; k < 2; k++) begin
            blend_transfer_point_select = k[0];
            settle(250);
            check(amplitude, 16'h3FFF >> k);
            pulse(w, p);
            check(near(w, (4 << k) * d16(250) * MIX_HI_CYC / 65535, 4), 1'b1);
            check(near(p, MIX_HI_CYC, 2), 1'b1);
        end
        settle(500);
        check(amplitude, d16(500));
        for (k = 1; k >= 0; k--) begin
            boostNeeded = k[0];
            switchClock = 1'b0;
            cyc(2);
            switchClock = 1'b1;
            w = 0;
            repeat (12) begin
                cyc(1);
                if (boostSwitch === 1'b1) w++;
            end
            check(w, k * MINON_CYC);
        end
        supplyOk = 1'b0;
        cyc(2);
        check({softStart, amplitude}, 0);
        enable = 1'b0;
        supplyOk = 1'b1;
        cyc(2);
        sinkGrounded = 6'h20;
        startUp();
        sinkLowest = 6'h20;
        cyc(2);
        check(feedbackSelect, 6'h00);
        sinkLowest = 6'h01;
        cyc(2);
        check(feedbackSelect, 6'h01);
        string_count_select = 3'h5;
        sinkLowest = 6'h02;
        cyc(2);
        check(feedbackSelect, 6'h00);
        end_of_test();
    end
endmodule : test_led_dimming_mode_control
